// >>> include/asm_pkg.sv
package asm_pkg;
  // widths
  localparam int NCH = 4;
  localparam int RW = 20;
  localparam int SW = 22;
  localparam int CW = 27;
  // clock rate
  localparam int CLK_MHZ = 125;
  localparam int CLK_KHZ = 125000;
  // combined payload ceiling in Mb/s
  localparam int CEIL_MBPS = 148;
  // rate measurement window
  localparam int RATE_WIN_US = 1000;
  localparam int RATE_WIN_CYC = RATE_WIN_US * CLK_MHZ;
  // alarm hysteresis
  localparam int ALM_HYST_MS = 1000;
  localparam int ALM_HYST_CYC = ALM_HYST_MS * CLK_KHZ;
  // led flash half period
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
  // serial activity hold, far longer than one 10-bit char at 19200 baud
  localparam int SER_HOLD_MS = 20;
  localparam int SER_HOLD_CYC = SER_HOLD_MS * CLK_KHZ;
  // reset values; alarms come up open until first evaluation
  localparam logic ALM_RST = 1'b1;
  localparam logic LED_RST = 1'b0;
endpackage

// >>> tb/asm_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side: four asi payload sources and the serial data sender
module asm_src_model
  import asm_pkg::*;
#(
  parameter int BIT_CYC = 4
)
(
  input wire logic core_clk_i,
  input wire logic [NCH-1:0][7:0] per_i,
  input wire logic send_i,
  input wire logic [7:0] char_i,
  output logic [NCH-1:0] byte_o,
  output logic ser_o
);
  int cnt [NCH];
  int bit_n = 0;
  logic [9:0] sh = 10'h3ff;
  // quiet lines at time zero
  initial
  begin
    byte_o = '0;
    ser_o = 1'b1;
    foreach (cnt[c])
      cnt[c] = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one strobe every per_i cycles; a period that divides the window
  // gives an exact count per window whatever the window phase
  always @(negedge core_clk_i)
  begin
    foreach (cnt[c])
    begin
      cnt[c] = per_i[c] == 8'h00 ? 0 : (cnt[c] + 1) % int'(per_i[c]);
      byte_o[c] <= per_i[c] != 8'h00 && cnt[c] == 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // receive-only line: nothing comes back, idle high between characters
  always @(negedge core_clk_i)
  begin
    if (bit_n > 0)
    begin
      bit_n--;
      if (bit_n % BIT_CYC == 0)
        sh = {1'b1, sh[9:1]};
    end
    else if (send_i)
    begin
      sh = {1'b1, char_i, 1'b0};
      bit_n = 10 * BIT_CYC;
    end
    ser_o <= sh[0];
  end
endmodule // asm_src_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import asm_pkg::*;
  localparam int WIN = 64;
  localparam int HYS = 20;
  localparam int BLK = 8;
  localparam int SER = 30;
  localparam int BIT = 4;
  localparam int CEIL = 148 * WIN / 1000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cap = 1'b0, ev = 1'b0, ov = 1'b0, sel = 1'b0, cod = 1'b0, dly = 1'b1, mute = 1'b0;
  logic sact = 1'b0, send = 1'b0, rx;
  logic [NCH-1:0] sv = '0, en = '1, p204 = '0, dv = '0, de = '1, dbv = '0, dp = '0, bv;
  logic [NCH-1:0][RW-1:0] lim = '0;
  logic [NCH-1:0][7:0] per = '0, dd = '0;
  logic [7:0] chr = 8'h00;
  logic cmaj, cmin, cdl, col, cor, osel, nrz, dmaj, dmin, ddl, dil;
  logic [NCH-1:0] cled, ralm, cp, pass, dled, dbvo, dpo, c0, c1, d0, d1;
  logic [NCH-1:0][RW-1:0] rate;
  logic [NCH-1:0][7:0] ddo;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int npass [NCH];
  int pats [$] = {32, 32, 16, 64, 16, 32, 32, 32, 8, 8, 0, 0, 0, 0, 0, 0};
  int limv [NCH] = '{4, 3, 3, 1};
  asm_status #(.WIN_CYC(WIN), .HYST_CYC(HYS), .BLK_CYC(BLK), .SER_CYC(SER)) i_asm_status (
    .core_clk_i(clk), .rst_i(rst), .cmb_byte_vld_i(bv), .cmb_sig_vld_i(sv), .cmb_pkt204_i(p204),
    .cmb_chan_en_i(en), .cmb_cap_en_i(cap), .cmb_chan_limit_i(lim), .ser_rx_i(rx), .dcb_elec_vld_i(ev),
    .dcb_opt_vld_i(ov), .input_select_switch_i(sel), .input_coding_switch_i(cod),
    .alarm_delay_switch_i(dly), .output_mute_switch_i(mute), .dcb_asi_vld_i(dv), .dcb_chan_en_i(de),
    .dcb_byte_vld_i(dbv), .dcb_data_i(dd), .dcb_pkt204_i(dp), .dcb_ser_act_i(sact),
    .cmb_major_o(cmaj), .cmb_minor_o(cmin), .cmb_chan_led_o(cled), .cmb_data_led_o(cdl),
    .cmb_out_led_o(col), .cmb_rate_alarm_o(ralm), .cmb_chan_rate_o(rate), .cmb_pkt204_o(cp),
    .cmb_pass_o(pass), .cmb_corrupt_o(cor), .dcb_opt_sel_o(osel), .dcb_nrz_mode_o(nrz),
    .dcb_major_o(dmaj), .dcb_minor_o(dmin), .dcb_chan_led_o(dled), .dcb_data_led_o(ddl),
    .dcb_in_led_o(dil), .dcb_byte_vld_o(dbvo), .dcb_data_o(ddo), .dcb_pkt204_o(dpo));
  asm_src_model #(.BIT_CYC(BIT)) i_asm_src_model (
    .core_clk_i(clk), .per_i(per), .send_i(send), .char_i(chr), .byte_o(bv), .ser_o(rx));
  ////////////////////////////////////////////////////////////////////////////
  // 125 MHz clock
  always #4 clk = ~clk;
  // hang guard, about five times the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // zero-extended compare, four-state exact
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // gathers led levels seen and kept strobes over n cycles
  task automatic watch(input int n);
    c0 = '0;
    c1 = '0;
    d0 = '0;
    d1 = '0;
    foreach (npass[c])
      npass[c] = 0;
    repeat (n)
    begin
      @(negedge clk);
      c0 |= ~cled;
      c1 |= cled;
      d0 |= ~dled;
      d1 |= dled;
      foreach (npass[c])
        npass[c] += int'(pass[c]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence; inputs change on the falling edge only
  initial
  begin
    int sum;
    int lst;
    int er [NCH];
    logic [NCH-1:0] ea;
    logic s;
    void'($urandom(32'h0f051f58));
    w(3);
    chk({cmaj, cmin, dmaj, dmin, cled, dled, cdl, ddl}, {4'hf, 10'h000});
    w(1);
    rst = 1'b0;
    sv = '1;
    for (int c = 0; c < NCH; c++)
      lim[c] = RW'(limv[c]);
    // rate patterns around the ceiling, first uncapped then capped
    for (int k = 0; k < 4; k++)
    begin
      for (int c = 0; c < NCH; c++)
        per[c] = 8'(pats[k * NCH + c]);
      cap = 1'b0;
      w(3 * WIN + 4);
      sum = 0;
      for (int c = 0; c < NCH; c++)
      begin
        er[c] = per[c] == 8'h00 ? 0 : WIN / int'(per[c]);
        sum += er[c];
        ea[c] = er[c] > limv[c];
        chk(rate[c], er[c]);
      end
      chk({cmaj, col, cor, ralm}, {sum > CEIL, sum > CEIL, sum > CEIL, 4'h0});
      cap = 1'b1;
      w(2 * WIN + 4);
      watch(WIN);
      chk({cmaj, col, ralm}, {sum > CEIL, 1'b0, ea});
      chk({c1, c0}, {4'hf, ea});
      for (int c = 0; c < NCH; c++)
        chk(npass[c], ea[c] ? 0 : er[c]);
    end
    // random validity and enables on both sides
    per = '0;
    cap = 1'b0;
    ev = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      sv = k == 0 ? '0 : NCH'($urandom);
      en = NCH'($urandom);
      dv = NCH'($urandom);
      de = NCH'($urandom);
      w(2);
      chk({cmin, dmin}, {sv == '0, dv == '0});
      watch(2 * BLK + 4);
      chk({c1, c0}, {sv, ~(sv & en)});
      chk({d1, d0}, {dv, ~(dv & de)});
    end
    // one character; the led holds until the last low bit plus the hold time
    chr = 8'($urandom);
    lst = 0;
    for (int i = 0; i < 8; i++)
      if (!chr[i])
        lst = i + 1;
    send <= 1'b1;
    w(1);
    send <= 1'b0;
    w((lst + 1) * BIT + SER - 4);
    chk(cdl, 1'b1);
    w(8);
    chk(cdl, 1'b0);
    sact = 1'b1;
    w(2);
    chk(ddl, 1'b1);
    sact = 1'b0;
    w(SER + 4);
    chk(ddl, 1'b0);
    // every select, validity and mute combination, immediate alarms
    de = '1;
    for (int k = 0; k < 16; k++)
    begin
      {mute, ev, ov, sel} = 4'(k);
      cod = 1'($urandom);
      dv = NCH'($urandom);
      dbv = NCH'($urandom);
      dd = 32'($urandom);
      dp = NCH'($urandom);
      p204 = NCH'($urandom);
      w(2);
      s = sel ? ov : ev;
      chk({dmaj, dil, osel, nrz}, {~s, ~s, sel, cod});
      chk({dmin, dled}, {~(s && dv != '0), s ? dv : 4'h0});
      chk({dbvo, ddo, dpo, cp}, {mute && !s ? 36'h0 : {dbv, dd}, dp, p204});
    end
    // delayed alarm: no change before the hold time has run
    dly = 1'b0;
    ev = 1'b1;
    sel = 1'b0;
    dv = '1;
    w(HYS + 4);
    chk({dmaj, dmin}, 2'b00);
    ev = 1'b0;
    w(HYS - 3);
    chk({dmaj, dmin}, 2'b00);
    w(6);
    chk({dmaj, dmin}, 2'b11);
    wrap_up();
  end
endmodule // tb
`default_nettype wire

// >>> verilog/asm_rate_meter.sv
`timescale 1ns/10ps
`default_nettype none
module asm_rate_meter
  import asm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic byte_i,
  input wire logic tick_i,
  output logic [RW-1:0] rate_o
);

  typedef struct packed {
    logic [RW-1:0] cnt;
    logic [RW-1:0] rate;
  } asm_meter_t;

  asm_meter_t s_q;
  asm_meter_t s_d;

  ////////////////////////////////////////////////////////////////
  // count bytes, latch the total at each window tick
  always_comb
  begin
    s_d = s_q;
    if (tick_i)
    begin
      s_d.rate = s_q.cnt;
      s_d.cnt = {{(RW-1){1'b0}}, byte_i};
    end
    else if (byte_i && s_q.cnt != {RW{1'b1}})
      s_d.cnt = s_q.cnt + 1'b1; // saturate rather than wrap
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rate_o = s_q.rate;

  ////////////////////////////////////////////////////////////////
  property p_latch;
    @(posedge core_clk_i) disable iff (rst_i)
    tick_i |=> rate_o == $past(s_q.cnt);
  endproperty
  a_latch: assert property (p_latch) else $error("rate not latched at tick");

endmodule // asm_rate_meter
`default_nettype wire

// >>> verilog/asm_status.sv
`timescale 1ns/10ps
`default_nettype none
module asm_status
  import asm_pkg::*;
#(
  parameter int WIN_CYC = RATE_WIN_CYC,
  parameter int HYST_CYC = ALM_HYST_CYC,
  parameter int BLK_CYC = BLINK_CYC,
  parameter int SER_CYC = SER_HOLD_CYC
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [NCH-1:0] cmb_byte_vld_i,
  input wire logic [NCH-1:0] cmb_sig_vld_i,
  input wire logic [NCH-1:0] cmb_pkt204_i,
  input wire logic [NCH-1:0] cmb_chan_en_i,
  input wire logic cmb_cap_en_i,
  input wire logic [NCH-1:0][RW-1:0] cmb_chan_limit_i,
  input wire logic ser_rx_i,
  input wire logic dcb_elec_vld_i,
  input wire logic dcb_opt_vld_i,
  input wire logic input_select_switch_i,
  input wire logic input_coding_switch_i,
  input wire logic alarm_delay_switch_i,
  input wire logic output_mute_switch_i,
  input wire logic [NCH-1:0] dcb_asi_vld_i,
  input wire logic [NCH-1:0] dcb_chan_en_i,
  input wire logic [NCH-1:0] dcb_byte_vld_i,
  input wire logic [NCH-1:0][7:0] dcb_data_i,
  input wire logic [NCH-1:0] dcb_pkt204_i,
  input wire logic dcb_ser_act_i,
  output logic cmb_major_o,
  output logic cmb_minor_o,
  output logic [NCH-1:0] cmb_chan_led_o,
  output logic cmb_data_led_o,
  output logic cmb_out_led_o,
  output logic [NCH-1:0] cmb_rate_alarm_o,
  output logic [NCH-1:0][RW-1:0] cmb_chan_rate_o,
  output logic [NCH-1:0] cmb_pkt204_o,
  output logic [NCH-1:0] cmb_pass_o,
  output logic cmb_corrupt_o,
  output logic dcb_opt_sel_o,
  output logic dcb_nrz_mode_o,
  output logic dcb_major_o,
  output logic dcb_minor_o,
  output logic [NCH-1:0] dcb_chan_led_o,
  output logic dcb_data_led_o,
  output logic dcb_in_led_o,
  output logic [NCH-1:0] dcb_byte_vld_o,
  output logic [NCH-1:0][7:0] dcb_data_o,
  output logic [NCH-1:0] dcb_pkt204_o
);

  // ceiling in bytes per measurement window
  localparam logic [SW-1:0] CEIL_BYTES = SW'((CEIL_MBPS * WIN_CYC) / (8 * CLK_MHZ));

  typedef struct packed {
    logic [CW-1:0] win;
    logic cmp;
    logic [CW-1:0] blk;
    logic blink;
    logic [CW-1:0] ser;
    logic cdat;
    logic [CW-1:0] dser;
    logic ddat;
    logic cmaj;
    logic cmin;
    logic oled;
    logic [NCH-1:0] ralm;
    logic [NCH-1:0] cled;
    logic [NCH-1:0] cpkt;
    logic [NCH-1:0] cpass;
    logic [CW-1:0] hmaj;
    logic [CW-1:0] hmin;
    logic dmaj;
    logic dmin;
    logic iled;
    logic osel;
    logic nrz;
    logic [NCH-1:0] dled;
    logic [NCH-1:0] dbyte;
    logic [NCH-1:0][7:0] ddata;
    logic [NCH-1:0] dpkt;
  } asm_st_t;

  asm_st_t s_q;
  asm_st_t s_d;
  logic tick;
  logic [NCH-1:0][RW-1:0] rate;
  logic [SW-1:0] sum;
  logic sum_over;
  logic sel_vld;
  logic [NCH-1:0] emb_vld;
  logic raw_maj;
  logic raw_min;

  ////////////////////////////////////////////////////////////////
  // one hysteresis step: output follows raw once it has differed long enough
  function automatic logic [CW:0] hyst_step(input logic raw, input logic out,
                                            input logic [CW-1:0] cnt, input logic imm);
    logic [CW:0] r;
    r = {out, {CW{1'b0}}};
    if (raw != out)
    begin
      if (imm || cnt >= CW'(HYST_CYC - 1))
        r = {raw, {CW{1'b0}}};
      else
        r = {out, cnt + 1'b1};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  // per channel byte counters; format-blind, so 188 and 204 count alike
  for (genvar g = 0; g < NCH; g++)
  begin : g_meter
    asm_rate_meter u_meter (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .byte_i(cmb_byte_vld_i[g]),
      .tick_i(tick),
      .rate_o(rate[g])
    );
  end

  // summed rate against the ceiling
  assign tick = (s_q.win == CW'(WIN_CYC - 1));
  assign sum = SW'(rate[0]) + SW'(rate[1]) + SW'(rate[2]) + SW'(rate[3]);
  assign sum_over = sum > CEIL_BYTES;

  // decombiner input selection; embedded channels only count with a live line
  assign sel_vld = input_select_switch_i ? dcb_opt_vld_i : dcb_elec_vld_i;
  assign emb_vld = dcb_asi_vld_i & {NCH{sel_vld}};
  assign raw_maj = !sel_vld;
  assign raw_min = !(|emb_vld);

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_d = s_q;
    // window and flash timers
    s_d.win = tick ? '0 : s_q.win + 1'b1;
    s_d.cmp = tick;
    if (s_q.blk >= CW'(BLK_CYC - 1))
    begin
      s_d.blk = '0;
      s_d.blink = !s_q.blink;
    end
    else
      s_d.blk = s_q.blk + 1'b1;
    // combiner alarms, one cycle behind the latched rates
    if (s_q.cmp)
    begin
      s_d.cmaj = sum_over;
      for (int i = 0; i < NCH; i++)
        s_d.ralm[i] = cmb_cap_en_i && rate[i] > cmb_chan_limit_i[i];
    end
    if (!cmb_cap_en_i)
      s_d.ralm = '0;
    // out led follows the new major value, so it never outlives the overload
    s_d.oled = s_d.cmaj && !cmb_cap_en_i;
    s_d.cmin = !(|cmb_sig_vld_i);
    // channel leds: steady when healthy, flashing when disabled or over limit
    for (int i = 0; i < NCH; i++)
    begin
      s_d.cled[i] = cmb_sig_vld_i[i] && ((cmb_chan_en_i[i] && !s_q.ralm[i]) || s_q.blink);
      s_d.dled[i] = emb_vld[i] && (dcb_chan_en_i[i] || s_q.blink);
    end
    s_d.cpkt = cmb_pkt204_i;
    // capping drops an over-limit channel; without capping every enabled channel passes
    s_d.cpass = cmb_byte_vld_i & cmb_chan_en_i & ~s_q.ralm;
    // serial receive activity: a low (start bit) restarts the hold
    if (!ser_rx_i)
    begin
      s_d.ser = CW'(SER_CYC - 1);
      s_d.cdat = 1'b1;
    end
    else if (s_q.ser != '0)
      s_d.ser = s_q.ser - 1'b1;
    else
      s_d.cdat = 1'b0;
    if (dcb_ser_act_i)
    begin
      s_d.dser = CW'(SER_CYC - 1);
      s_d.ddat = 1'b1;
    end
    else if (s_q.dser != '0)
      s_d.dser = s_q.dser - 1'b1;
    else
      s_d.ddat = 1'b0;
    // decombiner alarms with optional hysteresis
    {s_d.dmaj, s_d.hmaj} = hyst_step(raw_maj, s_q.dmaj, s_q.hmaj, alarm_delay_switch_i);
    {s_d.dmin, s_d.hmin} = hyst_step(raw_min, s_q.dmin, s_q.hmin, alarm_delay_switch_i);
    s_d.iled = raw_maj;
    s_d.osel = input_select_switch_i;
    s_d.nrz = input_coding_switch_i;
    // byte valid and data outputs repeat the embedded streams byte for byte, zeroed when muted with the selected input lost; the 204 flags are never muted
    if (output_mute_switch_i && !sel_vld)
    begin
      s_d.dbyte = '0;
      s_d.ddata = '0;
    end
    else
    begin
      s_d.dbyte = dcb_byte_vld_i;
      s_d.ddata = dcb_data_i;
    end
    s_d.dpkt = dcb_pkt204_i;
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.cmaj <= ALM_RST;
      s_q.cmin <= ALM_RST;
      s_q.dmaj <= ALM_RST;
      s_q.dmin <= ALM_RST;
      s_q.iled <= LED_RST;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign cmb_major_o = s_q.cmaj;
  assign cmb_minor_o = s_q.cmin;
  assign cmb_chan_led_o = s_q.cled;
  assign cmb_data_led_o = s_q.cdat;
  assign cmb_out_led_o = s_q.oled;
  assign cmb_rate_alarm_o = s_q.ralm;
  assign cmb_chan_rate_o = rate;
  assign cmb_pkt204_o = s_q.cpkt;
  assign cmb_pass_o = s_q.cpass;
  assign cmb_corrupt_o = s_q.oled;
  assign dcb_opt_sel_o = s_q.osel;
  assign dcb_nrz_mode_o = s_q.nrz;
  assign dcb_major_o = s_q.dmaj;
  assign dcb_minor_o = s_q.dmin;
  assign dcb_chan_led_o = s_q.dled;
  assign dcb_data_led_o = s_q.ddat;
  assign dcb_in_led_o = s_q.iled;
  assign dcb_byte_vld_o = s_q.dbyte;
  assign dcb_data_o = s_q.ddata;
  assign dcb_pkt204_o = s_q.dpkt;

  ////////////////////////////////////////////////////////////////
  // checks
  property p_cmb_major;
    @(posedge core_clk_i) disable iff (rst_i)
    s_q.cmp |=> cmb_major_o == $past(sum_over);
  endproperty
  a_cmb_major: assert property (p_cmb_major) else $error("major alarm wrong after window");

  property p_cmb_minor;
    @(posedge core_clk_i) disable iff (rst_i)
    (cmb_sig_vld_i == '0) [*2] |-> cmb_minor_o;
  endproperty
  a_cmb_minor: assert property (p_cmb_minor) else $error("minor alarm closed with no input");

  property p_out_led;
    @(posedge core_clk_i) disable iff (rst_i)
    cmb_out_led_o |-> cmb_major_o && !$past(cmb_cap_en_i);
  endproperty
  a_out_led: assert property (p_out_led) else $error("output led lit without overload");

  property p_chan_led;
    @(posedge core_clk_i) disable iff (rst_i)
    (cmb_sig_vld_i[0] && cmb_chan_en_i[0] && !cmb_cap_en_i) [*3] |-> cmb_chan_led_o[0];
  endproperty
  a_chan_led: assert property (p_chan_led) else $error("valid channel led dark");

  property p_dis_flash;
    @(posedge core_clk_i) disable iff (rst_i)
    (cmb_sig_vld_i[1] && !cmb_chan_en_i[1]) [*2] |-> cmb_chan_led_o[1] == $past(s_q.blink);
  endproperty
  a_dis_flash: assert property (p_dis_flash) else $error("disabled channel not flashing");

  property p_in_led;
    @(posedge core_clk_i) disable iff (rst_i)
    1 |=> dcb_in_led_o == !$past(input_select_switch_i ? dcb_opt_vld_i : dcb_elec_vld_i);
  endproperty
  a_in_led: assert property (p_in_led) else $error("input led ignores selected input");

  property p_imm;
    @(posedge core_clk_i) disable iff (rst_i)
    (alarm_delay_switch_i && !sel_vld) [*2] |-> dcb_major_o;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate major alarm late");

  property p_hyst;
    @(posedge core_clk_i) disable iff (rst_i)
    (!alarm_delay_switch_i && raw_min && !dcb_minor_o && s_q.hmin == '0) |=> !dcb_minor_o;
  endproperty
  a_hyst: assert property (p_hyst) else $error("minor alarm skipped hysteresis");

  property p_mute;
    @(posedge core_clk_i) disable iff (rst_i)
    (output_mute_switch_i && !sel_vld) |=> dcb_byte_vld_o == '0;
  endproperty
  a_mute: assert property (p_mute) else $error("outputs not muted");

  property p_ser;
    @(posedge core_clk_i) disable iff (rst_i)
    $fell(ser_rx_i) |=> cmb_data_led_o [*2];
  endproperty
  a_ser: assert property (p_ser) else $error("data led missed a start bit");

  property p_dser;
    @(posedge core_clk_i) disable iff (rst_i)
    dcb_ser_act_i |=> dcb_data_led_o;
  endproperty
  a_dser: assert property (p_dser) else $error("embedded data led dark");

  c_overload: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(cmb_major_o));
  c_loss: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(dcb_major_o));
  c_flash: cover property (@(posedge core_clk_i) disable iff (rst_i) $fell(cmb_chan_led_o[1]) && cmb_sig_vld_i[1]);

endmodule // asm_status
`default_nettype wire
